// file: hdl/cdr_clock_divider_ready_sync.v
// Processor clock divider, reset synchroniser and ready synchroniser
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "cdr_map.vh"
`default_nettype none

module cdr_clock_divider_ready_sync
(
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Clock sources
  input  wire        crystal_pin_a,
  output reg         crystal_pin_b,
  input  wire        external_freq_in,
  input  wire        counter_clear_align,
  // Clock outputs
  output reg         crystal_buffer_out,
  output reg         cpu_clk_out,
  output reg         periph_clk_out,
  // Reset
  input  wire        power_on_request_n,
  output reg         cpu_reset_out,
  // Ready path
  input  wire        bus_qualifier_one_n,
  input  wire        bus_qualifier_two_n,
  input  wire        bus_done_one,
  input  wire        bus_done_two,
  input  wire        sync_depth_select,
  output reg         ready_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [31:0] ctrl_ff;
  reg         src_prev_ff;
  reg  [1:0]  cnt_ff;
  reg         stage_one_ff;
  reg  [1:0]  nxt_cnt;
  reg         nxt_cpu_clk;
  wire        src_sel;
  wire        src_level;
  wire        src_rise;
  wire        clk_rise;
  wire        clk_fall;
  wire        ready_req;
  wire        addr_ok;
  wire        wr_en;
  wire        rd_setup;
  reg  [31:0] status;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign addr_ok = (paddr == `CDR_CTRL_OFS) || (paddr == `CDR_STAT_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & (paddr == `CDR_CTRL_OFS);

  // ****************************************************************
  // Read decode
  // ****************************************************************
  assign rd_setup = psel & ~penable & ~pwrite;

  // ****************************************************************
  // Status word
  // ****************************************************************
  always @*
  begin
    status = 32'h0000_0000;
    status[`CDR_STAT_CLK_BIT] = cpu_clk_out;
    status[`CDR_STAT_PER_BIT] = periph_clk_out;
    status[`CDR_STAT_RST_BIT] = cpu_reset_out;
    status[`CDR_STAT_RDY_BIT] = ready_out;
    status[`CDR_STAT_ST1_BIT] = stage_one_ff;
    status[`CDR_STAT_SRC_BIT] = src_sel;
    status[`CDR_STAT_CNT_MSB:`CDR_STAT_CNT_LSB] = cnt_ff;
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= `CDR_CTRL_RST;
    end
    else if (wr_en)
    begin
      ctrl_ff <= {31'h0, pwdata[`CDR_CTRL_SRC_BIT]};
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      if (paddr == `CDR_CTRL_OFS)
      begin
        prdata <= ctrl_ff;
      end
      else if (paddr == `CDR_STAT_OFS)
      begin
        prdata <= status;
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Source select and rising-edge detect
  // ****************************************************************
  assign src_sel   = ctrl_ff[`CDR_CTRL_SRC_BIT];
  assign src_level = src_sel ? external_freq_in : crystal_pin_a;
  assign src_rise  = src_level & ~src_prev_ff;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_prev_ff <= 1'b0;
    end
    else
    begin
      src_prev_ff <= src_level;
    end
  end

  // ****************************************************************
  // Oscillator buffer and feedback
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crystal_buffer_out <= 1'b0;
      crystal_pin_b      <= 1'b1;
    end
    else
    begin
      crystal_buffer_out <= crystal_pin_a;
      crystal_pin_b      <= ~crystal_pin_a;
    end
  end

  // ****************************************************************
  // Divide by three
  // ****************************************************************
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (counter_clear_align)
    begin
      nxt_cnt = `CDR_CNT_FIRST;
    end
    else if (src_rise)
    begin
      if (cnt_ff == `CDR_CNT_LAST)
      begin
        nxt_cnt = `CDR_CNT_FIRST;
      end
      else
      begin
        nxt_cnt = cnt_ff + 2'h1;
      end
    end
    nxt_cpu_clk = (nxt_cnt == `CDR_CNT_LAST);
  end

  // ****************************************************************
  // Clock events
  // ****************************************************************
  assign clk_rise = nxt_cpu_clk & ~cpu_clk_out;
  assign clk_fall = ~nxt_cpu_clk & cpu_clk_out;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff      <= `CDR_CNT_FIRST;
      cpu_clk_out <= 1'b0;
    end
    else
    begin
      cnt_ff      <= nxt_cnt;
      cpu_clk_out <= nxt_cpu_clk;
    end
  end

  // ****************************************************************
  // Peripheral clock
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_clk_out <= 1'b0;
    end
    else
    begin
      if (counter_clear_align)
      begin
        periph_clk_out <= 1'b0;
      end
      else if (clk_rise)
      begin
        periph_clk_out <= ~periph_clk_out;
      end
    end
  end

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_reset_out <= 1'b1;
    end
    else if (clk_fall)
    begin
      cpu_reset_out <= ~power_on_request_n;
    end
  end

  // ****************************************************************
  // Ready synchroniser
  // ****************************************************************
  assign ready_req = (~bus_qualifier_one_n & bus_done_one)
                   | (~bus_qualifier_two_n & bus_done_two);

  // ****************************************************************
  // Stage one
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_one_ff <= 1'b0;
    end
    else if (clk_rise)
    begin
      stage_one_ff <= ready_req;
    end
  end

  // ****************************************************************
  // Stage two
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_out <= 1'b0;
    end
    else
    begin
      if (clk_fall)
      begin
        if (sync_depth_select)
        begin
          ready_out <= ready_req;
        end
        else
        begin
          ready_out <= ready_req & stage_one_ff;
        end
      end
    end
  end

endmodule // cdr_clock_divider_ready_sync

`default_nettype wire

// file: hdl/cdr_map.vh
// Register map and constants of the processor clock generator
`ifndef CDR_MAP_VH
`define CDR_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CDR_CTRL_OFS       12'h000
`define CDR_STAT_OFS       12'h004

// ****************************************************************
// Control fields and reset value
// ****************************************************************
`define CDR_CTRL_SRC_BIT   0
`define CDR_CTRL_RST       32'h0000_0000

// ****************************************************************
// Status fields
// ****************************************************************
`define CDR_STAT_CLK_BIT   0
`define CDR_STAT_PER_BIT   1
`define CDR_STAT_RST_BIT   2
`define CDR_STAT_RDY_BIT   3
`define CDR_STAT_ST1_BIT   4
`define CDR_STAT_SRC_BIT   5
`define CDR_STAT_CNT_LSB   8
`define CDR_STAT_CNT_MSB   9

// ****************************************************************
// Divider counts
// ****************************************************************
`define CDR_CNT_FIRST      2'h0
`define CDR_CNT_LAST       2'h2

`endif

// file: testbench/cdr_properties.sv
// Checker on the clock generator ports
`timescale 1ns/1ps
`default_nettype none
module cdr_properties
(
  // Watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic counter_clear_align,
  input wire logic crystal_pin_a,
  input wire logic crystal_pin_b,
  input wire logic crystal_buffer_out,
  input wire logic cpu_clk_out,
  input wire logic periph_clk_out,
  input wire logic power_on_request_n,
  input wire logic cpu_reset_out,
  input wire logic bus_qualifier_one_n,
  input wire logic bus_qualifier_two_n,
  input wire logic bus_done_one,
  input wire logic bus_done_two,
  input wire logic sync_depth_select,
  input wire logic ready_out
);
  wire logic ready_req;
  assign ready_req = (~bus_qualifier_one_n & bus_done_one) | (~bus_qualifier_two_n & bus_done_two);
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_buf_copy: assert property ($past(presetn) |->
    crystal_buffer_out == $past(crystal_pin_a)) else $error("bad buffer");
  a_periph_step: assert property ($changed(periph_clk_out) |->
    $rose(cpu_clk_out) || $past(counter_clear_align)) else $error("bad periph");
  a_periph_rise: assert property ($rose(periph_clk_out) |-> cpu_clk_out)
    else $error("periph rise off clock");
  a_clk_hold: assert property ($rose(cpu_clk_out) && !counter_clear_align |=>
    cpu_clk_out) else $error("clock high too short");
  a_clear_hold: assert property ($past(counter_clear_align) |->
    !cpu_clk_out && !periph_clk_out) else $error("bad clear");
  a_reset_fall: assert property ($fell(cpu_clk_out) |->
    cpu_reset_out == !$past(power_on_request_n)) else $error("bad reset");
  a_reset_keep: assert property (!$fell(cpu_clk_out) |->
    $stable(cpu_reset_out)) else $error("reset moved");
  a_ready_fall: assert property ($changed(ready_out) |->
    $fell(cpu_clk_out)) else $error("ready moved");
  a_feedback_inv: assert property ($past(presetn) |->
    crystal_pin_b == !$past(crystal_pin_a)) else $error("bad feedback");
  a_ready_one: assert property ($fell(cpu_clk_out) && $past(sync_depth_select) |->
    ready_out == $past(ready_req)) else $error("bad one-stage ready");
  a_ready_drop: assert property ($fell(cpu_clk_out) && !$past(ready_req) |->
    !ready_out) else $error("ready not dropped");
endmodule // cdr_properties
bind cdr_clock_divider_ready_sync cdr_properties u_cdr_properties (.*);
`default_nettype wire

// file: testbench/cdr_far_side.sv
// Model of the clock and bus-done sources
`timescale 1ns/1ps
`default_nettype none
module cdr_far_side
(
  // Bench control
  input  wire logic [1:0] done_req,
  input  wire logic       pclk, slow,
  // Sources
  output var logic        crystal_pin_a, external_freq_in, bus_done_one, bus_done_two
);
  logic [2:0] div_ff = 3'h0;
  logic [1:0] late_ff = 2'h0;
  initial {crystal_pin_a, external_freq_in, bus_done_one, bus_done_two} = 4'h0;
  always @(posedge pclk)
  begin
    div_ff <= div_ff == 3'h5 ? 3'h0 : div_ff + 3'h1;
    crystal_pin_a <= div_ff < 3'h3;
    external_freq_in <= ~external_freq_in;
    late_ff <= done_req;
    {bus_done_two, bus_done_one} <= slow ? late_ff : done_req;
  end
endmodule // cdr_far_side
`default_nettype wire

// file: testbench/tb_clock_divider_ready_sync.sv
// Self-checking bench for the clock generator
`timescale 1ns/1ps
`default_nettype none
module tb_clock_divider_ready_sync;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        crystal_pin_a, crystal_pin_b, external_freq_in, counter_clear_align;
  logic        crystal_buffer_out, cpu_clk_out, periph_clk_out, power_on_request_n;
  logic        cpu_reset_out, bus_qualifier_one_n, bus_qualifier_two_n, bus_done_one;
  logic        bus_done_two, sync_depth_select, ready_out;
  logic [1:0]  done_req;
  int          bad_count, n_tests;
  cdr_clock_divider_ready_sync u_cdr_clock_divider_ready_sync (.*);
  cdr_far_side u_cdr_far_side (.*);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    repeat (9000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
  begin
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  end
  endtask
  task automatic meas(input int rises);
    int h, p, r;
    logic c;
  begin
    {h, p, r} = '0;
    c = cpu_clk_out;
    repeat (72)
    begin
      @(negedge pclk);
      h += cpu_clk_out;
      p += periph_clk_out;
      r += cpu_clk_out & ~c;
      c = cpu_clk_out;
    end
    chk(h, 24);
    chk(p, 36);
    chk(r, rises);
    $display("clock test done");
  end
  endtask
  task automatic complete_run();
  begin
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, slow, done_req} = '0;
    {counter_clear_align, power_on_request_n, sync_depth_select} = 3'h0;
    {bus_qualifier_one_n, bus_qualifier_two_n} = 2'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, 12'h00c, 32'h1);
    chk(err, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    @(posedge pclk);
    power_on_request_n <= 1'b1;
    repeat (30) @(negedge pclk);
    chk(cpu_reset_out, 1'b0);
    meas(4);
    apb(1'b1, 12'h000, 32'h1);
    repeat (12) @(negedge pclk);
    meas(12);
    @(negedge cpu_clk_out);
    @(posedge pclk);
    counter_clear_align <= 1'b1;
    repeat (5) @(negedge pclk);
    chk({cpu_clk_out, periph_clk_out}, 2'h0);
    @(posedge pclk);
    counter_clear_align <= 1'b0;
    repeat (12) @(negedge pclk);
    meas(12);
    for (int i = 0; i < 64; i++)
    begin
      @(posedge pclk);
      {slow, sync_depth_select, done_req, bus_qualifier_two_n, bus_qualifier_one_n} <= i[5:0];
      repeat (40) @(negedge pclk);
      chk(ready_out, |(done_req & ~{bus_qualifier_two_n, bus_qualifier_one_n}));
    end
    $display("ready test done");
    complete_run();
  end
endmodule // tb_clock_divider_ready_sync
`default_nettype wire
